// ==== logic/smp_pkg.sv ====
// Constants, types and helpers for the matrix polling sequencer
// Function
// - Optional matrix built only from inputs 4-15
// - Size 00 means all standard, standard time
// - Matrix inputs use matrix time, others standard
// - 4x4 uses sinks 4-7, sources 10-13
// - 5x5 uses sinks 4-8, sources 10-14
// - Three sizes; 6x6 sinks 4-9, sources 10-15
// - Poll all matrix combinations before standard inputs
// - Store matrix results as next reference
// - Cycle end raises interrupt and change flag
// - Status read clears flag, releases interrupt
// - First cycle always interrupts, later only changes
// - Thermal warning drops 10/15 mA to 2 mA
// - Matrix compares on the source side
// - Matrix interrupts gated by source enables
// - Matrix inputs ignore per-input disable
// - No debounce on matrix inputs
// - Matrix selected forbids continuous mode
// - Standard active time 64 to 2048 us
`default_nettype none

package smp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int TICK_W = 8;
  localparam int ACT_MIN_US = 64;
  localparam int ACT_MAX_US = 2048;
  localparam int ACT_W = 12;
  localparam logic [2:0] ACT_CODE_MAX = 3'h5;

  // ----------------------------------------------------------------
  // Inputs and matrix layout
  // ----------------------------------------------------------------
  localparam int N_IN = 24;
  localparam int SINK_BASE = 4;
  localparam int SRC_BASE = 10;
  localparam int MTX_BITS = 36;
  localparam int HALF_BITS = 18;
  localparam logic [1:0] SIZE_NONE = 2'h0;
  localparam logic [1:0] SIZE_4 = 2'h1;
  localparam logic [1:0] SIZE_5 = 2'h2;
  localparam logic [1:0] SIZE_6 = 2'h3;

  // Wetting current codes
  localparam logic [2:0] WC_2MA = 3'h2;
  localparam logic [2:0] WC_10MA = 3'h4;
  localparam logic [2:0] WC_15MA = 3'h5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] matrix_size;
    logic [2:0] standard_active_time;
    logic [2:0] matrix_active_time;
    logic [1:0] detection_debounce;
    logic thermal_reduction_off_source;
    logic thermal_reduction_off_sink;
    logic continuous_mode;
  } smp_cfg_t;

  typedef struct packed {
    logic [N_IN-1:0] source_on;
    logic [N_IN-1:0] sink_on;
    logic sample;
  } smp_drive_t;

  typedef enum logic [3:0] {
    SMP_IDLE = 4'h1,
    SMP_MTX = 4'h2,
    SMP_STD = 4'h4,
    SMP_WAIT = 4'h8
  } smp_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Active time in us, codes above the top clamp to the longest time
  function automatic logic [ACT_W-1:0] act_us(input logic [2:0] code);
    logic [2:0] c;
    c = (code > ACT_CODE_MAX) ? ACT_CODE_MAX : code;
    act_us = ACT_W'(ACT_MIN_US) << c;
  endfunction

  // Matrix edge length; zero when no matrix
  function automatic logic [2:0] mtx_n(input logic [1:0] size);
    unique case (size)
      SIZE_4: mtx_n = 3'h4;
      SIZE_5: mtx_n = 3'h5;
      SIZE_6: mtx_n = 3'h6;
      default: mtx_n = 3'h0;
    endcase
  endfunction

  // Input belongs to the active matrix as sink or source
  function automatic logic in_matrix(input int idx,
                                     input logic [1:0] size);
    int n;
    n = int'(mtx_n(size));
    in_matrix = (idx >= SINK_BASE && idx < SINK_BASE + n) ||
                (idx >= SRC_BASE && idx < SRC_BASE + n);
  endfunction

endpackage

`default_nettype wire

// ==== logic/smp_sequencer.sv ====
// Matrix and standard polling sequencer with change interrupt
`timescale 1ns/1ps
`default_nettype none

module smp_sequencer (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Configuration
  input wire smp_pkg::smp_cfg_t cfg,
  input wire logic trigger,
  input wire logic poll_tick,
  input wire logic [23:0] input_enable,
  input wire logic [23:0] current_source_input,
  input wire logic [23:0][2:0] wetting_cfg,
  input wire logic [23:0] comparator_irq_enable_a,
  input wire logic [23:0] comparator_irq_enable_b,
  // Analog front end pins
  input wire logic comp_above,
  input wire logic thermal_warning_event,
  // Status access
  input wire logic status_read,
  // Front end control
  output smp_pkg::smp_drive_t drive,
  output logic [23:0][2:0] wetting_eff,
  // Status
  output logic [23:0] std_status,
  output logic [17:0] matrix_result_lo,
  output logic [17:0] matrix_result_hi,
  output logic switch_change_flag,
  output logic int_n,
  output logic busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  smp_pkg::smp_state_t st_r, st_nxt;
  logic [smp_pkg::TICK_W-1:0] tick_r, tick_nxt;
  logic [smp_pkg::ACT_W-1:0] tmr_r, tmr_nxt;
  logic [2:0] snk_r, snk_nxt, src_r, src_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic first_r, first_nxt, chg_r, chg_nxt;
  logic pend_r, pend_nxt, trig_r, trig_nxt;
  logic [smp_pkg::MTX_BITS-1:0] mref_r, mref_nxt;
  logic [23:0] sref_r, sref_nxt;
  logic [23:0][1:0] deb_r, deb_nxt;
  smp_pkg::smp_drive_t drv_r, drv_nxt;
  logic [23:0][2:0] weff_r, weff_nxt;
  logic comp_s1_r, comp_s2_r, tw_s1_r, tw_s2_r;

  logic tick, done;
  logic [2:0] n_sz;
  logic [smp_pkg::ACT_W-1:0] mtx_load, std_load;

  // Standard time holds 64..2048 us; matrix time only with a matrix
  assign n_sz = smp_pkg::mtx_n(cfg.matrix_size);
  assign std_load = smp_pkg::act_us(cfg.standard_active_time) - 12'h001;
  assign mtx_load = smp_pkg::act_us(cfg.matrix_active_time) - 12'h001;
  assign tick = (tick_r == smp_pkg::TICK_W'(smp_pkg::TICK_CYC - 1));
  assign done = tick && (tmr_r == 12'h000);

  // Next polled standard input at or above a start index
  function automatic logic [5:0] find_std(input logic [5:0] from,
                                          input logic [23:0] en,
                                          input logic [1:0] size);
    logic [5:0] r;
    r = 6'h3F;
    for (int i = smp_pkg::N_IN - 1; i >= 0; i--) begin
      // disable honoured only outside the matrix
      if (i >= int'(from) && en[i] && !smp_pkg::in_matrix(i, size)) begin
        r = 6'(i);
      end
    end
    find_std = r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
      tw_s1_r <= 1'b0;
      tw_s2_r <= 1'b0;
    end else begin
      comp_s1_r <= comp_above;
      comp_s2_r <= comp_s1_r;
      tw_s1_r <= thermal_warning_event;
      tw_s2_r <= tw_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] nx;
    logic [5:0] b;
    logic cyc_end, start, src_role, nw;
    logic cont;
    nx = 6'h3F;
    b = 6'h00;
    cyc_end = 1'b0;
    start = 1'b0;
    src_role = 1'b0;
    nw = comp_s2_r;
    // Continuous operation only without a matrix
    cont = cfg.continuous_mode && (cfg.matrix_size == smp_pkg::SIZE_NONE);
    st_nxt = st_r;
    tick_nxt = tick ? '0 : tick_r + 8'h01;
    tmr_nxt = tick ? tmr_r - 12'h001 : tmr_r;
    snk_nxt = snk_r;
    src_nxt = src_r;
    idx_nxt = idx_r;
    first_nxt = first_r;
    chg_nxt = chg_r;
    trig_nxt = trigger;
    mref_nxt = mref_r;
    sref_nxt = sref_r;
    deb_nxt = deb_r;
    pend_nxt = pend_r & ~status_read;
    drv_nxt = '0;

    unique case (st_r)
      smp_pkg::SMP_IDLE: begin
        if (trigger && !trig_r) begin
          first_nxt = 1'b1;
          chg_nxt = 1'b0;
          start = 1'b1;
        end
      end
      smp_pkg::SMP_MTX: begin
        // Sink side grounded, compare on the source side
        drv_nxt.sink_on[smp_pkg::SINK_BASE + int'(snk_r)] = 1'b1;
        drv_nxt.source_on[smp_pkg::SRC_BASE + int'(src_r)] = 1'b1;
        if (done) begin
          drv_nxt.sample = 1'b1;
          b = 6'({3'h0, snk_r} * {3'h0, n_sz}) + {3'h0, src_r};
          // No debounce; interrupt gated by source enables
          if (!first_r && mref_r[b] != nw &&
              ((nw && comparator_irq_enable_a[smp_pkg::SRC_BASE +
                int'(src_r)]) ||
               (!nw && comparator_irq_enable_b[smp_pkg::SRC_BASE +
                int'(src_r)]))) begin
            chg_nxt = 1'b1;
          end
          mref_nxt[b] = nw;
          tmr_nxt = mtx_load;
          if (src_r == n_sz - 3'h1) begin
            src_nxt = 3'h0;
            if (snk_r == n_sz - 3'h1) begin
              // All combinations done, then standard inputs
              nx = find_std(6'h00, input_enable, cfg.matrix_size);
            end else begin
              snk_nxt = snk_r + 3'h1;
            end
          end else begin
            src_nxt = src_r + 3'h1;
          end
        end
      end
      smp_pkg::SMP_STD: begin
        if (cont) begin
          for (int i = 0; i < smp_pkg::N_IN; i++) begin
            drv_nxt.source_on[i] = input_enable[i] & current_source_input[i];
            drv_nxt.sink_on[i] = input_enable[i] & ~current_source_input[i];
          end
        end else if (current_source_input[idx_r]) begin
          drv_nxt.source_on[idx_r] = 1'b1;
        end else begin
          drv_nxt.sink_on[idx_r] = 1'b1;
        end
        if (done) begin
          drv_nxt.sample = 1'b1;
          tmr_nxt = std_load;
          if (first_r) begin
            sref_nxt[idx_r] = nw;
            deb_nxt[idx_r] = 2'h0;
          end else if (sref_r[idx_r] != nw) begin
            // Debounce: accept after setting+1 equal samples
            if (deb_r[idx_r] == cfg.detection_debounce) begin
              sref_nxt[idx_r] = nw;
              deb_nxt[idx_r] = 2'h0;
              if ((nw && comparator_irq_enable_a[idx_r]) ||
                  (!nw && comparator_irq_enable_b[idx_r])) begin
                chg_nxt = 1'b1;
              end
            end else begin
              deb_nxt[idx_r] = deb_r[idx_r] + 2'h1;
            end
          end else begin
            deb_nxt[idx_r] = 2'h0;
          end
          nx = find_std({1'b0, idx_r} + 6'h01, input_enable,
                        cfg.matrix_size);
        end
      end
      smp_pkg::SMP_WAIT: begin
        if (poll_tick) begin
          start = 1'b1;
        end
      end
    endcase

    // Leaving a step: next standard input or end of cycle
    if (done && (st_r == smp_pkg::SMP_STD ||
        (st_r == smp_pkg::SMP_MTX && src_r == n_sz - 3'h1 &&
         snk_r == n_sz - 3'h1))) begin
      if (nx == 6'h3F) begin
        cyc_end = 1'b1;
      end else begin
        st_nxt = smp_pkg::SMP_STD;
        idx_nxt = nx[4:0];
        tmr_nxt = std_load;
      end
    end

    // Cycle end: first always, later only on change
    if (cyc_end) begin
      if (first_r || chg_nxt) begin
        pend_nxt = 1'b1;
      end
      first_nxt = 1'b0;
      chg_nxt = 1'b0;
      st_nxt = smp_pkg::SMP_WAIT;
      start = cont;
    end

    // Cycle start: matrix group first when configured
    if (start) begin
      tick_nxt = '0;
      snk_nxt = 3'h0;
      src_nxt = 3'h0;
      if (cfg.matrix_size != smp_pkg::SIZE_NONE) begin
        st_nxt = smp_pkg::SMP_MTX;
        tmr_nxt = mtx_load;
      end else begin
        tmr_nxt = std_load;
        nx = find_std(6'h00, input_enable, cfg.matrix_size);
        if (nx == 6'h3F) begin
          // Nothing enabled: report the empty cycle only when it is the first
          st_nxt = smp_pkg::SMP_WAIT;
          if (first_nxt) begin
            pend_nxt = 1'b1;
          end
          first_nxt = 1'b0;
        end else begin
          st_nxt = smp_pkg::SMP_STD;
          idx_nxt = nx[4:0];
        end
      end
    end

    // Trigger low stops polling; references are kept
    if (!trigger) begin
      st_nxt = smp_pkg::SMP_IDLE;
      drv_nxt = '0;
    end

    // Thermal reduction of high currents, per role
    for (int i = 0; i < smp_pkg::N_IN; i++) begin
      src_role = smp_pkg::in_matrix(i, cfg.matrix_size) ?
                 (i >= smp_pkg::SRC_BASE) : current_source_input[i];
      weff_nxt[i] = wetting_cfg[i];
      if (tw_s2_r && !(src_role ? cfg.thermal_reduction_off_source :
                                  cfg.thermal_reduction_off_sink) &&
          (wetting_cfg[i] == smp_pkg::WC_10MA ||
           wetting_cfg[i] == smp_pkg::WC_15MA)) begin
        weff_nxt[i] = smp_pkg::WC_2MA;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= smp_pkg::SMP_IDLE;
      tick_r <= '0;
      tmr_r <= '0;
      snk_r <= 3'h0;
      src_r <= 3'h0;
      idx_r <= 5'h00;
      first_r <= 1'b0;
      chg_r <= 1'b0;
      pend_r <= 1'b0;
      trig_r <= 1'b0;
      mref_r <= '0;
      sref_r <= '0;
      deb_r <= '0;
      drv_r <= '0;
      weff_r <= '0;
    end else begin
      st_r <= st_nxt;
      tick_r <= tick_nxt;
      tmr_r <= tmr_nxt;
      snk_r <= snk_nxt;
      src_r <= src_nxt;
      idx_r <= idx_nxt;
      first_r <= first_nxt;
      chg_r <= chg_nxt;
      pend_r <= pend_nxt;
      trig_r <= trig_nxt;
      mref_r <= mref_nxt;
      sref_r <= sref_nxt;
      deb_r <= deb_nxt;
      drv_r <= drv_nxt;
      weff_r <= weff_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign drive = drv_r;
  assign wetting_eff = weff_r;
  assign std_status = sref_r;
  assign matrix_result_lo = mref_r[smp_pkg::HALF_BITS-1:0];
  assign matrix_result_hi = mref_r[smp_pkg::MTX_BITS-1:smp_pkg::HALF_BITS];
  assign switch_change_flag = pend_r;
  assign int_n = ~pend_r;
  assign busy = (st_r != smp_pkg::SMP_IDLE);

endmodule

`default_nettype wire

// ==== tb/smp_mcu_model.sv ====
// Host model that acknowledges the interrupt pin
`timescale 1ns/1ps
`default_nettype none

module smp_mcu_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Interrupt side
  input wire logic int_n,
  input wire logic ack_en,
  input wire logic [7:0] ack_delay,
  // Status read and count of acknowledges
  output logic status_read,
  output var int irq_count
);
  // Slow answers leave the pin low meanwhile, as a sleeping host would
  initial begin
    status_read = 1'b0;
    irq_count = 0;
    forever begin
      @(negedge mclk);
      if (nrst && ack_en && int_n === 1'b0) begin
        repeat (ack_delay) @(negedge mclk);
        status_read = 1'b1;
        irq_count++;
        @(negedge mclk);
        status_read = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ==== tb/smp_sequencer_assertions.sv ====
// Port checker for the polling sequencer
`timescale 1ns/1ps
`default_nettype none

module smp_sequencer_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Watched ports
  input wire smp_pkg::smp_cfg_t cfg,
  input wire logic trigger,
  input wire logic status_read,
  input wire smp_pkg::smp_drive_t drive,
  input wire logic switch_change_flag,
  input wire logic int_n,
  input wire logic busy
);
  // ------------------------------------------
  // Properties
  // ------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Start from idle with a matrix selected
  sequence s_start;
    !busy && $rose(trigger) && cfg.matrix_size != 2'h0;
  endsequence
  // First pairing is sink 4 against source 10
  sequence s_first_pair;
    drive.sink_on == 24'h000010 && drive.source_on == 24'h000400;
  endsequence
  // Both sides driven means a matrix combination, except in continuous standard polling
  sequence s_combo;
    |drive.sink_on && |drive.source_on;
  endsequence

  chk_first_pair: assert property (s_start |-> ##[1:3] s_first_pair)
    else $error("first matrix combination wrong");
  chk_pair_onehot: assert property (s_combo |-> cfg.matrix_size != 2'h0 &&
    $onehot(drive.sink_on) && $onehot(drive.source_on))
    else $error("combination not one sink and one source");
  chk_matrix_span: assert property (s_combo |-> drive.sink_on[9:4] != 6'h0 &&
    drive.source_on[15:10] != 6'h0)
    else $error("combination outside matrix inputs");
  chk_size_span: assert property (s_combo |->
    (cfg.matrix_size != 2'h1 ||
     (drive.sink_on[9:8] == 2'h0 && drive.source_on[15:14] == 2'h0)) &&
    (cfg.matrix_size != 2'h2 ||
     (!drive.sink_on[9] && !drive.source_on[15])))
    else $error("combination beyond matrix size");
  chk_step_hold: assert property ($rose(|drive.source_on) |=>
    $stable(drive.source_on) [*8])
    else $error("source drive changed inside a step");
  chk_sample_pulse: assert property (drive.sample |=> !drive.sample)
    else $error("sample pulse longer than one cycle");
  chk_flag_holds: assert property (switch_change_flag && !status_read |=>
    switch_change_flag)
    else $error("change flag dropped without a read");
  chk_clear_by_read: assert property ($fell(switch_change_flag) |->
    $past(status_read))
    else $error("change flag cleared with no read");
  chk_read_clears: assert property (status_read && !busy |=>
    !switch_change_flag && int_n)
    else $error("read did not release interrupt");
  chk_pin_follows: assert property (int_n != switch_change_flag)
    else $error("interrupt pin disagrees with flag");
  chk_idle_quiet: assert property (!trigger [*2] |-> !busy &&
    drive.sink_on == 24'h0 && drive.source_on == 24'h0)
    else $error("drive active without trigger");
endmodule

bind smp_sequencer smp_sequencer_assertions i_chk (
  .mclk(mclk), .nrst(nrst), .cfg(cfg), .trigger(trigger),
  .status_read(status_read), .drive(drive),
  .switch_change_flag(switch_change_flag), .int_n(int_n), .busy(busy)
);

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the polling sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic mclk, nrst, trigger, poll_tick, comp_above, tw_event, ack_en;
  logic status_read, flag, int_n, busy;
  logic [23:0] in_en, src_sel, en_a, en_b, std_status, role;
  logic [23:0][2:0] wet_cfg, wet_eff;
  logic [17:0] res_lo, res_hi;
  logic [7:0] ack_delay;
  smp_pkg::smp_cfg_t cfg;
  smp_pkg::smp_drive_t drive;
  int seed, mismatches, tests_run, irqs, sz;

  smp_sequencer i_dut (
    .mclk(mclk), .nrst(nrst), .cfg(cfg), .trigger(trigger),
    .poll_tick(poll_tick), .input_enable(in_en),
    .current_source_input(src_sel), .wetting_cfg(wet_cfg),
    .comparator_irq_enable_a(en_a), .comparator_irq_enable_b(en_b),
    .comp_above(comp_above), .thermal_warning_event(tw_event),
    .status_read(status_read), .drive(drive), .wetting_eff(wet_eff),
    .std_status(std_status), .matrix_result_lo(res_lo),
    .matrix_result_hi(res_hi), .switch_change_flag(flag), .int_n(int_n),
    .busy(busy)
  );

  smp_mcu_model i_mcu (
    .mclk(mclk), .nrst(nrst), .int_n(int_n), .ack_en(ack_en),
    .ack_delay(ack_delay), .status_read(status_read), .irq_count(irqs)
  );

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task automatic tally_and_finish();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp_vec(input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_vec(72'(got), 72'(exp));
  endtask

  // Bounded wait: 0 sample pulse, 1 flag set, 2 pin released
  task automatic wait_until(input int what, input int lim);
    int n;
    n = 0;
    while (!((what == 0 && drive.sample === 1'b1) ||
             (what == 1 && flag === 1'b1) ||
             (what == 2 && int_n === 1'b1))) begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        mismatches++;
        tally_and_finish();
      end
    end
  endtask

  // Hot die drops 10/15 mA codes to 2 mA unless that role opts out
  function automatic logic [71:0] exp_wet(input logic [23:0][2:0] c,
                                          input logic [23:0] rl,
                                          input logic hot,
                                          input smp_pkg::smp_cfg_t f);
    logic [23:0][2:0] e;
    for (int i = 0; i < 24; i++) begin
      e[i] = (hot && !(rl[i] ? f.thermal_reduction_off_source :
                       f.thermal_reduction_off_sink) &&
              (c[i] == 3'h4 || c[i] == 3'h5)) ? 3'h2 : c[i];
    end
    return e;
  endfunction

  // Free-running clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    seed = 26;
    mismatches = 0;
    tests_run = 0;
    nrst = 1'b0;
    trigger = 1'b0;
    poll_tick = 1'b0;
    comp_above = 1'b0;
    tw_event = 1'b0;
    ack_en = 1'b0;
    ack_delay = 8'h03;
    cfg = '0;
    in_en = '0;
    src_sel = '0;
    en_a = '0;
    en_b = '0;
    wet_cfg = '0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    // Random codes, warning and reduction bits in all four mixes
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 24; i++) begin
        wet_cfg[i] = 3'($unsigned($random(seed)) % 6);
      end
      src_sel = 24'($random(seed));
      tw_event = k[0];
      cfg.thermal_reduction_off_source = k[1];
      cfg.thermal_reduction_off_sink = k[0] ^ k[1];
      repeat (6) @(negedge mclk);
      cmp_vec(wet_eff, exp_wet(wet_cfg, src_sel, tw_event, cfg));
    end
    // Nothing enabled: the first cycle still interrupts
    trigger = 1'b1;
    wait_until(1, 100);
    cmp_bit(int_n, 1'b0);
    trigger = 1'b0;
    repeat (3) @(negedge mclk);
    ack_en = 1'b1;
    wait_until(2, 50);
    cmp_bit(flag, 1'b0);
    cmp_vec(72'(irqs), 72'h1);
    // 6x6 roles: 15 mA sinks over 1 mA sources, only sinks reduced
    cfg.matrix_size = 2'h3;
    src_sel = src_sel | 24'h0003F0;
    for (int i = 4; i < 10; i++) begin
      wet_cfg[i] = 3'h5;
      wet_cfg[i + 6] = 3'h1;
    end
    tw_event = 1'b1;
    cfg.thermal_reduction_off_source = 1'b1;
    cfg.thermal_reduction_off_sink = 1'b0;
    role = (src_sel & 24'hFF000F) | 24'h00FC00;
    repeat (6) @(negedge mclk);
    cmp_vec(wet_eff, exp_wet(wet_cfg, role, tw_event, cfg));
    // Each size starts at sink 4 and source 10, enables cleared on matrix
    for (sz = 1; sz < 4; sz++) begin
      cfg.matrix_size = 2'(sz);
      in_en = 24'($random(seed)) & 24'hFF000F;
      trigger = 1'b1;
      // Hold the first step long enough for the step-hold check
      repeat (12) @(negedge mclk);
      cmp_vec(72'(drive.sink_on), 72'h10);
      cmp_vec(72'(drive.source_on), 72'h400);
      if (sz == 1) begin
        comp_above = 1'b1;
        wait_until(0, 17000);
        repeat (3) @(negedge mclk);
        cmp_vec(72'(drive.sink_on), 72'h10);
        cmp_vec(72'(drive.source_on), 72'h800);
        cmp_vec(72'(res_lo), 72'h1);
        cmp_vec(72'(res_hi), 72'h0);
      end
      trigger = 1'b0;
      repeat (2) @(negedge mclk);
      cmp_vec(72'(drive), 72'h0);
      cmp_bit(busy, 1'b0);
    end
    // Input 0 alone: quiet when unchanged, flags on a rise to above
    cfg.matrix_size = 2'h0;
    in_en = 24'h1;
    en_a = 24'h1;
    trigger = 1'b1;
    for (int c = 0; c < 3; c++) begin
      comp_above = (c == 2);
      if (c > 0) begin
        poll_tick = 1'b1;
        @(negedge mclk);
        poll_tick = 1'b0;
      end
      wait_until(0, 17000);
      repeat (12) @(negedge mclk);
      cmp_vec(72'(irqs), 72'(2 + (c == 2)));
      cmp_bit(std_status[0], c == 2);
    end
    // Mid-run reset clears references and leaves the pin released
    trigger = 1'b0;
    nrst = 1'b0;
    @(negedge mclk);
    cmp_vec(72'(std_status), 72'h0);
    cmp_bit(int_n, 1'b1);
    nrst = 1'b1;
    @(negedge mclk);
    cmp_bit(busy, 1'b0);
    cmp_vec(72'(drive), 72'h0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
